// ### rtl/frst_map.svh
// Offsets-free constant map: timing figures and cycle counts for reset and suspend
`ifndef FRST_MAP_SVH
`define FRST_MAP_SVH
`define FRST_CLK_MHZ 20
`define FRST_HW_RECOVERY_NS 40
`define FRST_ARRAY_RECOVERY_US 30
`define FRST_PGM_SUSPEND_US 25
`define FRST_ERS_SUSPEND_US 30
`define FRST_HW_RECOVERY_CYC ((`FRST_HW_RECOVERY_NS * `FRST_CLK_MHZ + 999) / 1000)
`define FRST_ARRAY_RECOVERY_CYC (`FRST_ARRAY_RECOVERY_US * `FRST_CLK_MHZ)
`define FRST_PGM_SUSPEND_CYC (`FRST_PGM_SUSPEND_US * `FRST_CLK_MHZ)
`define FRST_ERS_SUSPEND_CYC (`FRST_ERS_SUSPEND_US * `FRST_CLK_MHZ)
// One chosen figure covers every long nonvolatile operation
`define FRST_LONG_OP_CYC 32'h0000_6590
`endif

// ### rtl/frst_pkg.sv
// Types for the flash reset and suspend sequencer
package frst_pkg;
  typedef enum logic [3:0] {
    FRST_OP_NONE = 4'h0,
    FRST_OP_VOLATILE = 4'h1,
    FRST_OP_ARRAY_PGM = 4'h2,
    FRST_OP_SECTOR_ERASE = 4'h3,
    FRST_OP_SUBSECTOR_ERASE = 4'h4,
    FRST_OP_OTP_LOCK = 4'h5,
    FRST_OP_STATUS_WRITE = 4'h6,
    FRST_OP_NV_CONFIG = 4'h7,
    FRST_OP_POWERDOWN = 4'h8,
    FRST_OP_PROTECT_PGM = 4'h9,
    FRST_OP_PASSWORD_PGM = 4'hA
  } frst_op_t;
  typedef enum logic [2:0] {
    FRST_ST_READY = 3'h0,
    FRST_ST_BUSY = 3'h1,
    FRST_ST_SUSP_WAIT = 3'h2,
    FRST_ST_SUSPENDED = 3'h3,
    FRST_ST_RECOVER = 3'h4
  } frst_state_t;
  typedef enum logic [2:0] {
    FRST_CMD_READ = 3'h0,
    FRST_CMD_ERASE = 3'h1,
    FRST_CMD_STATUS_WRITE = 3'h2,
    FRST_CMD_NV_CONFIG = 3'h3,
    FRST_CMD_OTP = 3'h4,
    FRST_CMD_PROGRAM = 3'h5,
    FRST_CMD_OTHER = 3'h6
  } frst_cmd_t;
  typedef struct packed {
    logic valid;
    frst_cmd_t cmd;
  } frst_req_t;
endpackage

// ### rtl/frst_sequencer.sv
// Reset recovery and suspend timing sequencer of a serial NOR flash
// Summary of operation
// - After a hardware reset in standby, execute-in-place, decode, read or volatile write, ready in 40 ns.
// - A hardware reset interrupting array program, sector erase, their suspend or resume, OTP or lock needs 30 us.
// - A hardware reset during a long nonvolatile operation keeps the device busy that long.
// - A software reset recovers in 40 ns from standby and in 30 us from array operations.
// - A software reset during a long nonvolatile operation keeps the device busy its full time.
// - Program suspend within 25 us, subsector erase suspend within 30 us; then reads only.
// - Sector erase suspend within 30 us; then all but erase, status, config and OTP commands.
`include "frst_map.svh"
module frst_sequencer #(
  parameter int unsigned LONG_OP_CYC = `FRST_LONG_OP_CYC,
  parameter int unsigned HW_CYC = `FRST_HW_RECOVERY_CYC,
  parameter int unsigned ARRAY_CYC = `FRST_ARRAY_RECOVERY_CYC,
  parameter int unsigned PGM_SUSP_CYC = `FRST_PGM_SUSPEND_CYC,
  parameter int unsigned ERS_SUSP_CYC = `FRST_ERS_SUSPEND_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic flash_reset_n_i,
  input wire logic sw_reset_i,
  input wire logic op_start_i,
  input wire frst_pkg::frst_op_t op_kind_i,
  input wire logic op_done_i,
  input wire logic suspend_i,
  input wire logic resume_i,
  input wire frst_pkg::frst_req_t req_i,
  output logic ready_o,
  output logic suspended_o,
  output logic cmd_accept_o,
  output frst_pkg::frst_state_t state_o
);
  localparam int CW = 24;
  // Counters are CW bits wide and are loaded with the count minus one
  if (LONG_OP_CYC == 0 || LONG_OP_CYC >= (1 << CW) || HW_CYC == 0 || HW_CYC >= (1 << CW)
      || ARRAY_CYC == 0 || ARRAY_CYC >= (1 << CW) || PGM_SUSP_CYC == 0
      || PGM_SUSP_CYC >= (1 << CW) || ERS_SUSP_CYC == 0 || ERS_SUSP_CYC >= (1 << CW))
  begin : g_bad_count
    $error("frst_sequencer: unsupported count");
  end

  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  frst_pkg::frst_state_t state_q;
  frst_pkg::frst_state_t state_d;
  frst_pkg::frst_op_t op_q;
  frst_pkg::frst_op_t op_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic fl_rst_q;
  logic fl_rst_d;
  logic any_reset;
  logic [CW-1:0] rec_cyc;
  logic long_op;
  logic array_op;

  always_comb
  begin
    long_op = (op_q == frst_pkg::FRST_OP_STATUS_WRITE) || (op_q == frst_pkg::FRST_OP_NV_CONFIG)
      || (op_q == frst_pkg::FRST_OP_SUBSECTOR_ERASE) || (op_q == frst_pkg::FRST_OP_POWERDOWN)
      || (op_q == frst_pkg::FRST_OP_PROTECT_PGM) || (op_q == frst_pkg::FRST_OP_PASSWORD_PGM);
    array_op = (op_q == frst_pkg::FRST_OP_ARRAY_PGM) || (op_q == frst_pkg::FRST_OP_SECTOR_ERASE)
      || (op_q == frst_pkg::FRST_OP_OTP_LOCK);
    // Reset pulse taken on its release edge so a short pulse is still seen
    any_reset = (fl_rst_q && flash_reset_n_i) || sw_reset_i;
    if (state_q == frst_pkg::FRST_ST_READY || op_q == frst_pkg::FRST_OP_VOLATILE)
    begin
      rec_cyc = CW'(HW_CYC);
    end
    else if (long_op)
    begin
      rec_cyc = CW'(LONG_OP_CYC);
    end
    else if (array_op || state_q == frst_pkg::FRST_ST_SUSPENDED)
    begin
      rec_cyc = CW'(ARRAY_CYC);
    end
    else
    begin
      rec_cyc = CW'(HW_CYC);
    end
  end

  always_comb
  begin
    state_d = state_q;
    op_d = op_q;
    cnt_d = (cnt_q != '0) ? cnt_q - CW'(1) : cnt_q;
    fl_rst_d = !flash_reset_n_i;
    if (!flash_reset_n_i)
    begin
      state_d = state_q;
    end
    else if (any_reset)
    begin
      state_d = frst_pkg::FRST_ST_RECOVER;
      op_d = frst_pkg::FRST_OP_NONE;
      cnt_d = rec_cyc - CW'(1);
    end
    else
    begin
      case (state_q)
        frst_pkg::FRST_ST_READY:
        begin
          if (op_start_i && op_kind_i != frst_pkg::FRST_OP_NONE)
          begin
            op_d = op_kind_i;
            state_d = frst_pkg::FRST_ST_BUSY;
          end
        end
        frst_pkg::FRST_ST_BUSY:
        begin
          if (op_done_i)
          begin
            state_d = frst_pkg::FRST_ST_READY;
            op_d = frst_pkg::FRST_OP_NONE;
          end
          else if (suspend_i && (op_q == frst_pkg::FRST_OP_ARRAY_PGM
                   || op_q == frst_pkg::FRST_OP_SECTOR_ERASE
                   || op_q == frst_pkg::FRST_OP_SUBSECTOR_ERASE))
          begin
            state_d = frst_pkg::FRST_ST_SUSP_WAIT;
            cnt_d = (op_q == frst_pkg::FRST_OP_ARRAY_PGM) ? CW'(PGM_SUSP_CYC - 1)
              : CW'(ERS_SUSP_CYC - 1);
          end
        end
        frst_pkg::FRST_ST_SUSP_WAIT:
        begin
          if (cnt_q == '0)
          begin
            state_d = frst_pkg::FRST_ST_SUSPENDED;
          end
        end
        frst_pkg::FRST_ST_SUSPENDED:
        begin
          if (resume_i)
          begin
            state_d = frst_pkg::FRST_ST_BUSY;
          end
        end
        frst_pkg::FRST_ST_RECOVER:
        begin
          if (cnt_q == '0)
          begin
            state_d = frst_pkg::FRST_ST_READY;
          end
        end
        default:
        begin
          state_d = frst_pkg::FRST_ST_READY;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
    begin
      state_q <= frst_pkg::FRST_ST_READY;
      op_q <= frst_pkg::FRST_OP_NONE;
      cnt_q <= '0;
      fl_rst_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      fl_rst_q <= fl_rst_d;
    end
  end

  logic sector_block;
  always_comb
  begin
    sector_block = (req_i.cmd == frst_pkg::FRST_CMD_ERASE)
      || (req_i.cmd == frst_pkg::FRST_CMD_STATUS_WRITE)
      || (req_i.cmd == frst_pkg::FRST_CMD_NV_CONFIG) || (req_i.cmd == frst_pkg::FRST_CMD_OTP);
    cmd_accept_o = 1'b0;
    if (req_i.valid && flash_reset_n_i)
    begin
      case (state_q)
        frst_pkg::FRST_ST_READY:
        begin
          cmd_accept_o = 1'b1;
        end
        frst_pkg::FRST_ST_SUSPENDED:
        begin
          if (op_q == frst_pkg::FRST_OP_SECTOR_ERASE)
          begin
            cmd_accept_o = !sector_block;
          end
          else
          begin
            cmd_accept_o = (req_i.cmd == frst_pkg::FRST_CMD_READ);
          end
        end
        default:
        begin
          cmd_accept_o = 1'b0;
        end
      endcase
    end
  end

  assign ready_o = (state_q == frst_pkg::FRST_ST_READY);
  assign suspended_o = (state_q == frst_pkg::FRST_ST_SUSPENDED);
  assign state_o = state_q;

  // A fresh reset edge in the last recovery cycle restarts recovery, so it is excluded
  recover_bound_a: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_q)
    (state_q == frst_pkg::FRST_ST_RECOVER && cnt_q == '0 && flash_reset_n_i && !any_reset)
      |=> ready_o) else $error("recovery did not end");
  hw_fast_a: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_q)
    (sw_reset_i && ready_o && flash_reset_n_i) |=> ##1 ready_o)
    else $error("standby recovery too slow");
  susp_reads_a: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_q)
    (suspended_o && op_q != frst_pkg::FRST_OP_SECTOR_ERASE && cmd_accept_o)
      |-> req_i.cmd == frst_pkg::FRST_CMD_READ) else $error("non-read taken in suspend");
  sector_block_a: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_q)
    (suspended_o && op_q == frst_pkg::FRST_OP_SECTOR_ERASE && req_i.valid
      && flash_reset_n_i) |-> cmd_accept_o == (req_i.cmd inside {frst_pkg::FRST_CMD_READ,
      frst_pkg::FRST_CMD_PROGRAM, frst_pkg::FRST_CMD_OTHER}))
    else $error("sector suspend filter wrong");
  busy_block_a: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_q)
    (state_q inside {frst_pkg::FRST_ST_RECOVER, frst_pkg::FRST_ST_BUSY,
      frst_pkg::FRST_ST_SUSP_WAIT}) |-> !cmd_accept_o)
    else $error("command taken while busy");
  long_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_q)
    (sw_reset_i && flash_reset_n_i && long_op && state_q == frst_pkg::FRST_ST_BUSY)
      |=> cnt_q == CW'(LONG_OP_CYC - 1)) else $error("long recovery not loaded");
  array_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_q)
    (sw_reset_i && flash_reset_n_i && array_op && state_q == frst_pkg::FRST_ST_BUSY)
      |=> cnt_q == CW'(ARRAY_CYC - 1)) else $error("array recovery not loaded");
  pgm_susp_a: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_q)
    (state_q == frst_pkg::FRST_ST_BUSY && suspend_i && !op_done_i && !any_reset
      && flash_reset_n_i && op_q == frst_pkg::FRST_OP_ARRAY_PGM)
      |=> cnt_q == CW'(PGM_SUSP_CYC - 1)) else $error("program suspend latency wrong");
  hw_release_a: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_q)
    ($rose(flash_reset_n_i) && !sw_reset_i) |=> state_q == frst_pkg::FRST_ST_RECOVER)
    else $error("hardware reset not seen");
endmodule // frst_sequencer

// ### tb/frst_host_model.sv
// Host controller model driving reset pin, command strobes and requests
module frst_host_model (
  input wire logic sys_clk_i,
  input wire logic cmd_accept_i,
  output logic flash_reset_n_o,
  output logic [4:0] strobe_o,
  output frst_pkg::frst_op_t op_kind_o,
  output frst_pkg::frst_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    flash_reset_n_o = 1'h1;
    strobe_o = 5'h00;
    op_kind_o = frst_pkg::FRST_OP_NONE;
    req_o = '0;
  end
  // Strobe order: start, sw reset, done, suspend, resume; each a one-cycle pulse
  task automatic strobe(input logic [4:0] m, input frst_pkg::frst_op_t k);
    @(posedge sys_clk_i);
    strobe_o <= m;
    op_kind_o <= k;
    @(posedge sys_clk_i);
    strobe_o <= 5'h00;
  endtask
  // Two cycles low gives 100 ns, so the pulse is never marginal
  task automatic hw_reset();
    @(posedge sys_clk_i);
    flash_reset_n_o <= 1'h0;
    repeat (2) @(posedge sys_clk_i);
    flash_reset_n_o <= 1'h1;
  endtask
  // One idle cycle after each command covers both deselect minimums
  task automatic query(input frst_pkg::frst_cmd_t c, output logic acc);
    @(posedge sys_clk_i);
    req_o <= {1'h1, c};
    @(negedge sys_clk_i);
    acc = cmd_accept_i;
    @(posedge sys_clk_i);
    req_o.valid <= 1'h0;
  endtask
endmodule // frst_host_model

// ### tb/frst_sequencer_test.sv
// Self-checking bench for the flash reset and suspend sequencer
module frst_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {frst_pkg::frst_state_t st; logic [15:0] len;} frst_note_t;
  localparam int LONG_C = 20, ARRAY_C = 10, PGM_C = 5, ERS_C = 6;
  localparam frst_pkg::frst_state_t RDY = frst_pkg::FRST_ST_READY;
  localparam frst_pkg::frst_state_t BSY = frst_pkg::FRST_ST_BUSY;
  localparam frst_pkg::frst_state_t REC = frst_pkg::FRST_ST_RECOVER;
  localparam frst_pkg::frst_state_t SUS = frst_pkg::FRST_ST_SUSPENDED;
  logic sys_clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic flash_reset_n, ready, suspended, accept, acc, exp;
  logic [4:0] stb;
  frst_pkg::frst_op_t kind;
  frst_pkg::frst_req_t req;
  frst_pkg::frst_state_t state;
  frst_pkg::frst_state_t last_st = RDY;
  frst_note_t notes[$];
  frst_note_t mon_n;
  int fails = 0;
  int tests_run = 0;
  int cnt = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  frst_host_model i_host (.sys_clk_i(sys_clk_i), .cmd_accept_i(accept),
    .flash_reset_n_o(flash_reset_n), .strobe_o(stb), .op_kind_o(kind), .req_o(req));
  frst_sequencer #(.LONG_OP_CYC(20), .ARRAY_CYC(10), .PGM_SUSP_CYC(5), .ERS_SUSP_CYC(6)) i_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .flash_reset_n_i(flash_reset_n),
    .sw_reset_i(stb[3]), .op_start_i(stb[4]), .op_kind_i(kind), .op_done_i(stb[2]),
    .suspend_i(stb[1]), .resume_i(stb[0]), .req_i(req), .ready_o(ready),
    .suspended_o(suspended), .cmd_accept_o(accept), .state_o(state));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] ex);
    tests_run++;
    if (seen !== ex)
    begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", what, ex, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // A length of zero means the time spent in the previous state is free
  task automatic note(input frst_pkg::frst_state_t s, input int l);
    notes.push_back({s, 16'(l)});
  endtask
  task automatic wait_st(input frst_pkg::frst_state_t s);
    int i;
    for (i = 0; i < 200 && !(state === s && notes.size() == 0); i++)
      @(negedge sys_clk_i);
    if (i == 200)
    begin
      check("state wait", 16'(state), 16'(s));
      complete_run();
    end
  endtask
  always @(negedge sys_clk_i)
  begin
    if (state !== last_st)
    begin
      mon_n = notes.size() ? notes.pop_front() : '1;
      check("state", 16'(state), 16'(mon_n.st));
      if (mon_n.len != 0)
        check("duration", 16'(cnt), mon_n.len);
      check("ready level", 16'(ready), 16'(state == RDY));
      check("suspended level", 16'(suspended), 16'(state == SUS));
      last_st = state;
      cnt = 1;
    end
    else
      cnt++;
  end
  initial
  begin
    int start;
    frst_pkg::frst_cmd_t c;
    static frst_pkg::frst_op_t kinds [11] = '{frst_pkg::FRST_OP_NONE,
      frst_pkg::FRST_OP_VOLATILE, frst_pkg::FRST_OP_ARRAY_PGM, frst_pkg::FRST_OP_SECTOR_ERASE,
      frst_pkg::FRST_OP_OTP_LOCK, frst_pkg::FRST_OP_STATUS_WRITE, frst_pkg::FRST_OP_NV_CONFIG,
      frst_pkg::FRST_OP_SUBSECTOR_ERASE, frst_pkg::FRST_OP_POWERDOWN,
      frst_pkg::FRST_OP_PROTECT_PGM, frst_pkg::FRST_OP_PASSWORD_PGM};
    static int recov [11] = '{1, 1, ARRAY_C, ARRAY_C, ARRAY_C, LONG_C, LONG_C, LONG_C, LONG_C,
      LONG_C, LONG_C};
    static frst_pkg::frst_op_t sops [3] = '{frst_pkg::FRST_OP_ARRAY_PGM,
      frst_pkg::FRST_OP_SUBSECTOR_ERASE, frst_pkg::FRST_OP_SECTOR_ERASE};
    static int swait [3] = '{PGM_C, ERS_C, ERS_C};
    // Host spacing before a suspend in 50 ns cycles: 5 us, 50 us and 150 us
    static int space [3] = '{100, 1000, 3000};
    void'($urandom(32'h886644e5));
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    repeat (3) @(posedge sys_clk_i);
    // Even passes use the reset pin, odd passes the software reset
    for (int i = 0; i < 22; i++)
    begin
      if (kinds[i / 2] != frst_pkg::FRST_OP_NONE)
      begin
        note(BSY, 0);
        i_host.strobe(5'h10, kinds[i / 2]);
        i_host.query(frst_pkg::frst_cmd_t'(3'($urandom % 7)), acc);
        check("busy accept", 16'(acc), 16'h0000);
      end
      note(REC, 0);
      note(RDY, recov[i / 2]);
      if (i % 2)
        i_host.strobe(5'h08, kinds[i / 2]);
      else
        i_host.hw_reset();
      wait_st(RDY);
      i_host.query(frst_pkg::frst_cmd_t'(3'($urandom % 7)), acc);
      check("ready accept", 16'(acc), 16'h0001);
    end
    $display("test reset recovery done");
    for (int i = 0; i < 3; i++)
    begin
      note(BSY, 0);
      i_host.strobe(5'h10, sops[i]);
      repeat (space[i]) @(posedge sys_clk_i);
      note(frst_pkg::FRST_ST_SUSP_WAIT, 0);
      note(SUS, swait[i]);
      i_host.strobe(5'h02, sops[i]);
      wait_st(SUS);
      start = $urandom % 7;
      for (int k = 0; k < 7; k++)
      begin
        c = frst_pkg::frst_cmd_t'(3'((start + k) % 7));
        i_host.query(c, acc);
        exp = !(c inside {frst_pkg::FRST_CMD_ERASE, frst_pkg::FRST_CMD_STATUS_WRITE,
          frst_pkg::FRST_CMD_NV_CONFIG, frst_pkg::FRST_CMD_OTP});
        if (i < 2)
          exp = (c == frst_pkg::FRST_CMD_READ);
        check("suspended accept", 16'(acc), 16'(exp));
      end
      note(i == 2 ? REC : BSY, 0);
      note(RDY, i == 2 ? ARRAY_C : 0);
      i_host.strobe(i == 2 ? 5'h08 : 5'h01, sops[i]);
      if (i < 2)
        i_host.strobe(5'h04, sops[i]);
      wait_st(RDY);
    end
    $display("test suspend done");
    note(BSY, 0);
    // No write-protect pin here, so status_write_disable is taken as clear
    i_host.strobe(5'h10, frst_pkg::FRST_OP_STATUS_WRITE);
    i_host.strobe(5'h02, frst_pkg::FRST_OP_STATUS_WRITE);
    repeat (8) @(negedge sys_clk_i);
    check("ignored suspend", 16'(state), 16'(BSY));
    note(RDY, 0);
    i_host.strobe(5'h04, frst_pkg::FRST_OP_STATUS_WRITE);
    wait_st(RDY);
    $display("test ignored suspend done");
    complete_run();
  end
endmodule // frst_sequencer_test
